/* logic/adhs_defines.svh */
// offsets, field positions and reset values for the drive/head and status bank
// assumes a byte-wide task-file port with a 4-bit register offset
`ifndef ADHS_DEFINES_SVH
`define ADHS_DEFINES_SVH

// register offsets on the task-file port
`define ADHS_OFF_SECTOR 4'h3
`define ADHS_OFF_CYL_LO 4'h4
`define ADHS_OFF_CYL_HI 4'h5
`define ADHS_OFF_DRV_HEAD 4'h6
`define ADHS_OFF_STATUS 4'h7
`define ADHS_OFF_ALT_STATUS 4'he

// drive/head fields
`define ADHS_DH_LBA_BIT 6
`define ADHS_DH_DRIVE_SELECT_BIT 4
`define ADHS_DH_FIXED_MASK 8'ha0

// status fields
`define ADHS_ST_BUSY 7
`define ADHS_ST_RDY 6
`define ADHS_ST_WRITE_FAULT 5
`define ADHS_ST_SEEK_COMPLETE 4
`define ADHS_ST_DATA_REQUEST 3
`define ADHS_ST_CORRECTED 2
`define ADHS_ST_INDEX_ZERO 1
`define ADHS_ST_ERR 0

// reset values
`define ADHS_DH_RESET 8'ha0

`endif

/* logic/adhs_pkg.sv */
// types for the drive/head and status register bank
// assumes adhs_defines.svh is available to the modules that use these types
package adhs_pkg;

	// host access strobes for one cycle
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} adhs_req_t;

	// core status inputs from the card engine
	typedef struct packed {
		logic busy;
		logic ready;
		logic write_fault;
		logic data_req;
		logic corrected;
		logic error;
	} adhs_core_t;

	// addressing mode
	typedef enum logic {
		ADHS_MODE_CHS,
		ADHS_MODE_LBA
	} adhs_mode_t;

	// whole state of the bank
	typedef struct packed {
		logic [7:0] drv_head;
		logic [7:0] sector;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] rdata;
		logic irq_pending;
		logic corrected_seen;
	} adhs_state_t;

endpackage : adhs_pkg

/* logic/adhs_bank.sv */
// drive/head select, status and shadow status registers of the task file
// assumes one-cycle read/write strobes synchronous to i_mclk from the host port
// Operation
// - drive/head bits 7 and 5 read one
// - bit 6 selects chs or lba
// - lba built from sector, cylinders, head nibble
// - bit 4 selects drive matched to copy
// - status read clears interrupt, shadow does not
// - busy bit set, others invalid
// - dma request only with busy or data request
// - ready clear from reset until able
// - bit 5 reports write fault
// - seek complete set when ready
// - data request set when transfer needed
// - corrected error bit, read continues
// - status bit 1 reads zero
// - bit 0 reports error of last command
// - keep failing sector address in registers
// - interrupt only while disable bit clear
`timescale 1ns/1ns
`include "adhs_defines.svh"

module adhs_bank (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// host task-file port
	input wire adhs_pkg::adhs_req_t i_req,
	output logic [7:0] o_rdata,
	// card engine side
	input wire adhs_pkg::adhs_core_t i_core,
	input wire logic i_drive_copy,
	input wire logic i_irq_event,
	input wire logic i_int_disable,
	input wire logic i_dma_phase,
	input wire logic i_dma_want,
	input wire logic i_fail_load,
	input wire logic [27:0] i_fail_addr,
	// decoded addressing
	output adhs_pkg::adhs_mode_t o_mode,
	output logic [27:0] o_lba,
	output logic [3:0] o_head,
	output logic o_selected,
	// requests toward host
	output logic o_irq,
	output logic o_dmarq
);

	// state register and its next value
	adhs_pkg::adhs_state_t state_q; // everything the bank remembers
	adhs_pkg::adhs_state_t state_d; // next value, filled by the one comb process
	logic [7:0] status_w; // live status byte, shared by both status offsets
	logic rd_status_w; // primary status read taken this cycle
	logic rd_shadow_w; // shadow status read taken this cycle
	logic wr_command_w; // command write taken this cycle

	// builds the status byte; used for both the primary and shadow copy
	// bits below busy pass through even while busy is set; the host must ignore them
	function automatic logic [7:0] adhs_status(input adhs_pkg::adhs_core_t c, input logic seen);
		logic [7:0] s;
		s = 8'h00;
		s[`ADHS_ST_BUSY] = c.busy;
		s[`ADHS_ST_RDY] = c.ready;
		s[`ADHS_ST_WRITE_FAULT] = c.write_fault;
		s[`ADHS_ST_SEEK_COMPLETE] = c.ready;
		s[`ADHS_ST_DATA_REQUEST] = c.data_req;
		s[`ADHS_ST_CORRECTED] = seen;
		s[`ADHS_ST_INDEX_ZERO] = 1'b0;
		s[`ADHS_ST_ERR] = c.error;
		return s;
	endfunction : adhs_status

	// one strobe aimed at one offset; shared by the next-state logic and the checks
	function automatic logic adhs_hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] off);
		return strobe && (addr == off);
	endfunction : adhs_hit

	// live status and the decoded strobes; the status read and command write carry side effects, the shadow read none
	assign status_w = adhs_status(i_core, state_q.corrected_seen);
	assign rd_status_w = adhs_hit(i_req.rd, i_req.addr, `ADHS_OFF_STATUS);
	assign rd_shadow_w = adhs_hit(i_req.rd, i_req.addr, `ADHS_OFF_ALT_STATUS);
	assign wr_command_w = adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_STATUS);

	// next-state logic: register writes, read data and interrupt flag
	always_comb begin
		state_d = state_q;
		// corrected flag is sticky until the next command starts; it never aborts a read
		if (i_core.corrected) begin
			state_d.corrected_seen = 1'b1;
		end else if (wr_command_w) begin
			// a new command starts from a clean status
			state_d.corrected_seen = 1'b0;
		end
		// writes; command-block writes are not gated by busy, the host keeps off
		if (i_req.wr) begin
			unique case (i_req.addr)
				`ADHS_OFF_DRV_HEAD: begin
					state_d.drv_head = i_req.wdata | `ADHS_DH_FIXED_MASK;
				end
				`ADHS_OFF_SECTOR: begin
					state_d.sector = i_req.wdata;
				end
				`ADHS_OFF_CYL_LO: begin
					state_d.cyl_lo = i_req.wdata;
				end
				`ADHS_OFF_CYL_HI: begin
					state_d.cyl_hi = i_req.wdata;
				end
				default: begin
					// other offsets belong to other blocks
				end
			endcase
		end
		// failing sector address left for the host, wins over a host write
		if (i_fail_load) begin
			state_d.sector = i_fail_addr[7:0];
			state_d.cyl_lo = i_fail_addr[15:8];
			state_d.cyl_hi = i_fail_addr[23:16];
			state_d.drv_head = {state_q.drv_head[7:4], i_fail_addr[27:24]} | `ADHS_DH_FIXED_MASK;
		end
		// read data captured into a flop
		if (i_req.rd) begin
			unique case (i_req.addr)
				`ADHS_OFF_DRV_HEAD: begin
					state_d.rdata = state_q.drv_head;
				end
				`ADHS_OFF_SECTOR: begin
					state_d.rdata = state_q.sector;
				end
				`ADHS_OFF_CYL_LO: begin
					state_d.rdata = state_q.cyl_lo;
				end
				`ADHS_OFF_CYL_HI: begin
					state_d.rdata = state_q.cyl_hi;
				end
				`ADHS_OFF_STATUS, `ADHS_OFF_ALT_STATUS: begin
					state_d.rdata = status_w;
				end
				default: begin
					state_d.rdata = 8'h00;
				end
			endcase
		end
		// pending interrupt: primary status read clears, a new event wins
		if (i_irq_event) begin
			state_d.irq_pending = 1'b1;
		end else if (rd_status_w) begin
			state_d.irq_pending = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q.drv_head <= `ADHS_DH_RESET;
			state_q.sector <= 8'h00;
			state_q.cyl_lo <= 8'h00;
			state_q.cyl_hi <= 8'h00;
			state_q.rdata <= 8'h00;
			state_q.irq_pending <= 1'b0;
			state_q.corrected_seen <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// read data and decoded views of the drive/head and address registers
	assign o_rdata = state_q.rdata;
	assign o_mode = state_q.drv_head[`ADHS_DH_LBA_BIT] ? adhs_pkg::ADHS_MODE_LBA
		: adhs_pkg::ADHS_MODE_CHS;
	assign o_lba = {state_q.drv_head[3:0], state_q.cyl_hi, state_q.cyl_lo, state_q.sector};
	assign o_head = state_q.drv_head[3:0];
	assign o_selected = state_q.drv_head[`ADHS_DH_DRIVE_SELECT_BIT] == i_drive_copy;

	// interrupt is suppressed by the disable bit but stays pending, so a host that
	// unmasks interrupts again still sees the event that arrived while masked
	assign o_irq = state_q.irq_pending && !i_int_disable;

	// dma request gated by busy or data request during the data phase; left combinational
	// so the gate closes in the very cycle both flags drop
	assign o_dmarq = i_dma_phase && i_dma_want && (i_core.busy || i_core.data_req);

	// checks: each one watches what this bank drives; the host keeps its own rules

	// drive/head fixed bits always one, whatever the host or the engine loaded
	chk_dh_fixed_ones: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(state_q.drv_head & `ADHS_DH_FIXED_MASK) == `ADHS_DH_FIXED_MASK)
		else $error("drive/head fixed bits not one");

	// a drive/head read shows the fixed ones to the host
	chk_dh_read_ones: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.rd, i_req.addr, `ADHS_OFF_DRV_HEAD) |=> o_rdata[7] && o_rdata[5])
		else $error("drive/head read lost a fixed bit");

	// mode follows bit 6 written
	chk_mode_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_DRV_HEAD) && !i_fail_load |=>
		(o_mode == adhs_pkg::ADHS_MODE_LBA) == $past(i_req.wdata[`ADHS_DH_LBA_BIT]))
		else $error("mode does not follow bit 6");

	// lba top nibble follows the written head nibble
	chk_lba_nibble: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_DRV_HEAD) && !i_fail_load |=>
		o_lba[27:24] == $past(i_req.wdata[3:0]))
		else $error("lba high nibble wrong");

	// lba low byte follows the sector register
	chk_lba_sector: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_SECTOR) && !i_fail_load |=>
		o_lba[7:0] == $past(i_req.wdata))
		else $error("lba sector byte wrong");

	// lba middle bytes follow the cylinder registers
	chk_lba_cyl_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_CYL_LO) && !i_fail_load |=>
		o_lba[15:8] == $past(i_req.wdata))
		else $error("lba cylinder low byte wrong");
	chk_lba_cyl_high: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_CYL_HI) && !i_fail_load |=>
		o_lba[23:16] == $past(i_req.wdata))
		else $error("lba cylinder high byte wrong");

	// head number is the same low nibble, whatever the mode
	chk_head_nibble: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_DRV_HEAD) && !i_fail_load |=>
		o_head == $past(i_req.wdata[3:0]))
		else $error("head number wrong");

	// select follows the written drive bit against the copy field
	chk_drive_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		adhs_hit(i_req.wr, i_req.addr, `ADHS_OFF_DRV_HEAD) && !i_fail_load |=>
		o_selected == ($past(i_req.wdata[`ADHS_DH_DRIVE_SELECT_BIT]) == i_drive_copy))
		else $error("drive select mismatch");

	// primary read clears pending
	chk_status_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w && !i_irq_event |=> !state_q.irq_pending)
		else $error("status read did not clear interrupt");
	// shadow read keeps it
	chk_shadow_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_shadow_w && state_q.irq_pending |=> state_q.irq_pending)
		else $error("shadow read cleared interrupt");
	// a new event is pending the cycle after it arrives
	chk_irq_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_irq_event |=> state_q.irq_pending)
		else $error("interrupt event not held pending");

	// status byte fields, same on both offsets, seen the cycle after the read
	chk_status_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_BUSY] == $past(i_core.busy))
		else $error("status busy bit wrong");
	// ready stays clear until the engine says it can take a command
	chk_status_ready: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_RDY] == $past(i_core.ready))
		else $error("status ready bit wrong");
	// write fault
	chk_write_fault: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_WRITE_FAULT] == $past(i_core.write_fault))
		else $error("status write fault bit wrong");
	// seek complete mirrors ready
	chk_seek_complete: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_SEEK_COMPLETE] == $past(i_core.ready))
		else $error("status seek complete bit wrong");
	// data request
	chk_data_request: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_DATA_REQUEST] == $past(i_core.data_req))
		else $error("status data request bit wrong");
	// bit 1 never set
	chk_index_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> !o_rdata[`ADHS_ST_INDEX_ZERO])
		else $error("status bit 1 set");
	// error of the last command
	chk_error_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		rd_status_w || rd_shadow_w |=> o_rdata[`ADHS_ST_ERR] == $past(i_core.error))
		else $error("status error bit wrong");

	// corrected flag stays until a command write
	chk_corrected_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_core.corrected || (state_q.corrected_seen && !wr_command_w) |=> state_q.corrected_seen)
		else $error("corrected flag lost before a command");
	// and that write clears it unless a new correction lands with it
	chk_corrected_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wr_command_w && !i_core.corrected |=> !state_q.corrected_seen)
		else $error("command write left corrected flag set");

	// failing sector address replaces the command block
	chk_fail_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_fail_load |=> o_lba == $past(i_fail_addr))
		else $error("failing sector address not kept");

	// dma request never without busy or data request
	chk_dma_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		o_dmarq |-> i_core.busy || i_core.data_req)
		else $error("dma request without busy or data request");

	// interrupt never while disabled
	chk_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_int_disable |-> !o_irq)
		else $error("interrupt raised while disabled");
	// an unmasked event shows on the request the next cycle
	chk_irq_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		i_irq_event ##1 !i_int_disable |-> o_irq)
		else $error("unmasked interrupt not raised");

endmodule : adhs_bank

/* testbench/adhs_host_model.sv */
// host-side model: one task-file access per call of acc
// assumes the bench calls acc from a single process
`timescale 1ns/1ns
module adhs_host_model (
	// clock
	input wire logic i_mclk,
	// busy as the host sees it
	input wire logic i_busy,
	// strobes toward the bank
	output adhs_pkg::adhs_req_t o_req
);
	initial o_req = '0;
	// one-cycle strobe; never issues a command while the card is busy
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		while (w && a == 4'h7 && i_busy) @(posedge i_mclk);
		o_req <= '{rd: !w, wr: w, addr: a, wdata: v};
		@(posedge i_mclk);
		o_req <= '0;
	endtask : acc
endmodule : adhs_host_model

/* testbench/adhs_bank_tb_top.sv */
// self-checking bench: random task-file traffic plus irq and fail-address cases
// assumes the host model issues every register access
`timescale 1ns/1ns
module adhs_bank_tb_top;
	logic i_mclk, i_rst_b, copy, irq_ev, dis, dph, dwant, fload, sel, irq, dmarq;
	adhs_pkg::adhs_core_t core; // engine status levels
	adhs_pkg::adhs_req_t req; // host strobes
	adhs_pkg::adhs_mode_t mode; // decoded mode
	logic [27:0] faddr, lba; // failing address in, decoded address out
	logic [7:0] rdata, d, s; // read data and scratch bytes
	logic [3:0] head; // decoded head
	int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h9de7a5ea;
	adhs_bank adhs_bank_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .o_rdata(rdata),
		.i_core(core), .i_drive_copy(copy), .i_irq_event(irq_ev), .i_int_disable(dis),
		.i_dma_phase(dph), .i_dma_want(dwant), .i_fail_load(fload), .i_fail_addr(faddr),
		.o_mode(mode), .o_lba(lba), .o_head(head), .o_selected(sel), .o_irq(irq),
		.o_dmarq(dmarq));
	adhs_host_model adhs_host_model_inst (.i_mclk(i_mclk), .i_busy(core.busy), .o_req(req));
	// 50 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	// compare any result up to 28 bits
	task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// read data lands the cycle after the strobe is taken
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		adhs_host_model_inst.acc(1'b0, a, 8'h00);
		#1 v = rdata;
	endtask : rd
	// a write shows one cycle after it is taken
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		adhs_host_model_inst.acc(1'b1, a, v);
		@(posedge i_mclk);
		#1;
	endtask : wr
	// expected status byte; seek complete follows ready, bit 1 stays low
	function automatic logic [7:0] exp_st(input adhs_pkg::adhs_core_t c);
		return {c.busy, c.ready, c.write_fault, c.ready, c.data_req, c.corrected, 1'b0, c.error};
	endfunction : exp_st
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	// hang guard, well above the expected run
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		{i_rst_b, copy, irq_ev, dis, dph, dwant, fload} = '0;
		core = '0;
		faddr = '0;
		repeat (5) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(4'h6, d);
		cmp(d, 8'ha0);
		rd(4'h7, d);
		cmp(d[6], 1'b0);
		rd(4'h2, d);
		cmp(d, 8'h00);
		for (int i = 0; i < 40; i++) begin
			d = $random(seed);
			@(posedge i_mclk);
			copy <= $random(seed);
			{dph, dwant} <= $random(seed);
			core <= '0;
			wr(4'h6, d);
			rd(4'h6, s);
			cmp(s, d | 8'ha0);
			cmp(mode, d[6]);
			cmp(head, d[3:0]);
			cmp(sel, d[4] == copy);
			wr(4'h3, d ^ 8'h5a);
			wr(4'h4, ~d);
			wr(4'h5, d + 8'h01);
			cmp(lba, {d[3:0], d + 8'h01, ~d, d ^ 8'h5a});
			wr(4'h7, 8'h00);
			@(posedge i_mclk);
			core <= 6'($random(seed));
			rd(4'h7, s);
			cmp(s, exp_st(core));
			rd(4'he, s);
			cmp(s, exp_st(core));
			cmp(dmarq, dph & dwant & (core.busy | core.data_req));
		end
		@(posedge i_mclk);
		irq_ev <= 1'b1;
		@(posedge i_mclk);
		irq_ev <= 1'b0;
		rd(4'he, d);
		cmp(irq, 1'b1);
		@(posedge i_mclk);
		dis <= 1'b1;
		#1 cmp(irq, 1'b0);
		@(posedge i_mclk);
		dis <= 1'b0;
		#1 cmp(irq, 1'b1);
		rd(4'h7, d);
		cmp(irq, 1'b0);
		// failing address lands in the same cycle as a host sector write and must win
		fork
			adhs_host_model_inst.acc(1'b1, 4'h3, 8'h11);
			begin
				@(posedge i_mclk);
				fload <= 1'b1;
				faddr <= 28'h9a5c3e1;
				@(posedge i_mclk);
				fload <= 1'b0;
			end
		join
		@(posedge i_mclk);
		#1 cmp(lba, 28'h9a5c3e1);
		// corrected flag is sticky until the next command write
		@(posedge i_mclk);
		core <= '{corrected: 1'b1, default: 1'b0};
		@(posedge i_mclk);
		core <= '0;
		rd(4'h7, d);
		cmp(d[2], 1'b1);
		wr(4'h7, 8'h00);
		rd(4'he, d);
		cmp(d[2], 1'b0);
		// reset again in mid-run; registers fall back, first access right after release
		@(posedge i_mclk);
		i_rst_b <= 1'b0;
		@(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(4'h6, d);
		cmp(d, 8'ha0);
		cmp(lba, 28'h0000000);
		print_verdict();
	end
endmodule : adhs_bank_tb_top
